/* rtl/deterioration_diagnosis_monitor.sv */
// Top of the deterioration diagnosis monitor with its register port
`include "ddm_consts.svh"
`default_nettype none
module deterioration_diagnosis_monitor #(
    parameter int MS_CYCLES = `DDM_MS_NS / `DDM_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic wr_stb_i,
    input wire logic rd_stb_i,
    output logic [31:0] rd_data_o,
    // Drive signals
    input wire ddm_pkg::val_t motor_speed_i,
    input wire ddm_pkg::val_t torque_cmd_i,
    input wire ddm_pkg::est_t est_i,
    input wire ddm_pkg::est_stat_t est_stat_i,
    // Outputs
    output logic diag_speed_flag_o,
    output logic wear_warning_o
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic ddm_pkg::val_t clamp(input int d, input int lo, input int hi);
        int r;
        r = (d < lo) ? lo : ((d > hi) ? hi : d);
        clamp = ddm_pkg::val_t'(r);
    endfunction

    function automatic logic [13:0] clamp_time(input int d);
        int r;
        r = (d < 0) ? 0 : ((d > `DDM_TIME_MAX) ? `DDM_TIME_MAX : d);
        clamp_time = r[13:0];
    endfunction

    // ----------------------------------------
    // Settings
    // ----------------------------------------
    logic [31:0] feature_ext_cfg3;
    logic [13:0] converge_judge_time;
    ddm_pkg::lim_pair_t est_lim [4];
    ddm_pkg::lim_pair_t torque_avg_lim;
    ddm_pkg::val_t diag_speed_setpoint;
    ddm_pkg::val_t speed_match_width;
    logic [13:0] torque_avg_time;
    logic [3:0] autotune_est_speed;
    logic monitor_en;
    int wd;

    assign wd = int'($signed(wr_data_i));
    assign monitor_en = feature_ext_cfg3[`DDM_EN_BIT];

    // Out-of-range writes saturate instead of being refused
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            feature_ext_cfg3 <= `DDM_RST_CFG;
            converge_judge_time <= `DDM_RST_TIME;
            for (int i = 0; i < 4; i++) begin
                est_lim[i] <= {`DDM_RST_VAL, `DDM_RST_VAL};
            end
            torque_avg_lim <= {`DDM_RST_VAL, `DDM_RST_VAL};
            diag_speed_setpoint <= `DDM_RST_VAL;
            speed_match_width <= `DDM_RST_VAL;
            torque_avg_time <= `DDM_RST_TIME;
            autotune_est_speed <= `DDM_RST_SPEED;
        end else if (wr_stb_i) begin
            unique case (addr_i)
                `DDM_OFS_CFG: feature_ext_cfg3 <= wr_data_i;
                `DDM_OFS_CONV: converge_judge_time <= clamp_time(wd);
                `DDM_OFS_INER_UP: est_lim[0].upper <= clamp(wd, `DDM_POS_MIN, `DDM_POS_MAX);
                `DDM_OFS_INER_LO: est_lim[0].lower <= clamp(wd, `DDM_POS_MIN, `DDM_POS_MAX);
                `DDM_OFS_UNBAL_UP: est_lim[1].upper <= clamp(wd, `DDM_SGN_MIN, `DDM_SGN_MAX);
                `DDM_OFS_UNBAL_LO: est_lim[1].lower <= clamp(wd, `DDM_SGN_MIN, `DDM_SGN_MAX);
                `DDM_OFS_DYN_UP: est_lim[2].upper <= clamp(wd, `DDM_SGN_MIN, `DDM_SGN_MAX);
                `DDM_OFS_DYN_LO: est_lim[2].lower <= clamp(wd, `DDM_SGN_MIN, `DDM_SGN_MAX);
                `DDM_OFS_VISC_UP: est_lim[3].upper <= clamp(wd, `DDM_POS_MIN, `DDM_POS_MAX);
                `DDM_OFS_VISC_LO: est_lim[3].lower <= clamp(wd, `DDM_POS_MIN, `DDM_POS_MAX);
                `DDM_OFS_SPEED_SET: diag_speed_setpoint <= clamp(wd, `DDM_SPD_MIN, `DDM_SPD_MAX);
                `DDM_OFS_AVG_TIME: torque_avg_time <= clamp_time(wd);
                `DDM_OFS_TRQ_UP: torque_avg_lim.upper <= clamp(wd, `DDM_SGN_MIN, `DDM_SGN_MAX);
                `DDM_OFS_TRQ_LO: torque_avg_lim.lower <= clamp(wd, `DDM_SGN_MIN, `DDM_SGN_MAX);
                `DDM_OFS_MATCH_W: speed_match_width <= clamp(wd, `DDM_POS_MIN, `DDM_SPD_MAX);
                `DDM_OFS_EST_SPEED: autotune_est_speed <= 4'(clamp(wd, `DDM_POS_MIN, `DDM_EST_MAX));
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // Millisecond tick
    // ----------------------------------------
    logic [17:0] tick_cnt;
    logic ms_tick;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tick_cnt <= 18'h00000;
            ms_tick <= 1'b0;
        end else if (tick_cnt == 18'(MS_CYCLES - 1)) begin
            tick_cnt <= 18'h00000;
            ms_tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 18'h00001;
            ms_tick <= 1'b0;
        end
    end

    // ----------------------------------------
    // Diagnosis speed window
    // ----------------------------------------
    int speed_err;
    int abs_err;
    logic in_on;
    logic in_hold;
    logic diag_flag;
    logic next_diag_flag;

    assign speed_err = int'(motor_speed_i) - int'(diag_speed_setpoint);
    assign abs_err = (speed_err < 0) ? -speed_err : speed_err;
    assign in_on = abs_err <= int'(speed_match_width);
    // Release only beyond the widened band, so edge noise cannot chatter
    assign in_hold = abs_err <= int'(speed_match_width) + `DDM_HYST_RPM;
    assign next_diag_flag = monitor_en && (diag_flag ? in_hold : in_on);

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            diag_flag <= 1'b0;
        end else begin
            diag_flag <= next_diag_flag;
        end
    end

    // ----------------------------------------
    // Torque average
    // ----------------------------------------
    ddm_pkg::val_t torque_avg;
    logic torque_eff;
    logic torque_exceed;

    torque_averager u_avg (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .window_i(diag_flag),
        .tick_i(ms_tick),
        .avg_time_i(torque_avg_time),
        .torque_i(torque_cmd_i),
        .avg_o(torque_avg),
        .valid_o(torque_eff)
    );

    limit_judge #(.LIM_MIN(`DDM_SGN_MIN), .LIM_MAX(`DDM_SGN_MAX), .SHIFT(0)) u_trq_judge (
        .value_i(torque_avg),
        .lim_i(torque_avg_lim),
        .judge_i(torque_eff),
        .exceed_o(torque_exceed)
    );

    // ----------------------------------------
    // Load characteristic convergence
    // ----------------------------------------
    ddm_pkg::load_state_t load_state;
    logic [6:0] sub_ms;
    logic [13:0] accum_units;
    logic [13:0] conv_target;
    logic run_ok;
    logic load_eff;

    // Slower estimation needs longer before the estimate can be trusted
    assign conv_target = (converge_judge_time != 14'h0000) ? converge_judge_time :
                         `DDM_AUTO_CONV_BASE / {10'h000, autotune_est_speed};
    assign run_ok = monitor_en && est_stat_i.est_on &&
                    (autotune_est_speed != 4'h0);
    assign load_eff = (load_state == ddm_pkg::LJ_EFFECTIVE);

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            load_state <= ddm_pkg::LJ_IDLE;
            sub_ms <= 7'h00;
            accum_units <= 14'h0000;
        end else if (!run_ok) begin
            load_state <= ddm_pkg::LJ_IDLE;
            sub_ms <= 7'h00;
            accum_units <= 14'h0000;
        end else begin
            unique case (load_state)
                ddm_pkg::LJ_IDLE: load_state <= ddm_pkg::LJ_ACCUM;
                ddm_pkg::LJ_ACCUM: begin
                    if (accum_units >= conv_target && est_stat_i.converged) begin
                        load_state <= ddm_pkg::LJ_EFFECTIVE;
                    end else if (ms_tick && est_stat_i.cond_ok) begin
                        // Total time counts; gaps in the conditions do not restart it
                        if (sub_ms == `DDM_CONV_UNIT_MS - 7'h01) begin
                            sub_ms <= 7'h00;
                            if (accum_units != 14'h3FFF) begin
                                accum_units <= accum_units + 14'h0001;
                            end
                        end else begin
                            sub_ms <= sub_ms + 7'h01;
                        end
                    end
                end
                ddm_pkg::LJ_EFFECTIVE: load_state <= ddm_pkg::LJ_EFFECTIVE;
                default: load_state <= ddm_pkg::LJ_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Load limit checks and warning
    // ----------------------------------------
    ddm_pkg::val_t est_val [4];
    logic [3:0] est_exceed;
    localparam int LMIN [4] = '{`DDM_POS_MIN, `DDM_SGN_MIN, `DDM_SGN_MIN, `DDM_POS_MIN};
    localparam int LMAX [4] = '{`DDM_POS_MAX, `DDM_SGN_MAX, `DDM_SGN_MAX, `DDM_POS_MAX};
    localparam int LSHIFT [4] = '{0, 1, 1, 1};

    assign est_val[0] = est_i.inertia;
    assign est_val[1] = est_i.unbal;
    assign est_val[2] = est_i.dynfric;
    assign est_val[3] = est_i.viscfric;

    for (genvar g = 0; g < 4; g++) begin : g_est
        limit_judge #(.LIM_MIN(LMIN[g]), .LIM_MAX(LMAX[g]), .SHIFT(LSHIFT[g])) u_judge (
            .value_i(est_val[g]),
            .lim_i(est_lim[g]),
            .judge_i(load_eff),
            .exceed_o(est_exceed[g])
        );
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wear_warning_o <= 1'b0;
        end else begin
            wear_warning_o <= (|est_exceed) || torque_exceed;
        end
    end

    assign diag_speed_flag_o = diag_flag;

    // ----------------------------------------
    // Read-back
    // ----------------------------------------
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_data_o <= 32'h00000000;
        end else if (!rd_stb_i) begin
            rd_data_o <= 32'h00000000;
        end else begin
            unique case (addr_i)
                `DDM_OFS_CFG: rd_data_o <= feature_ext_cfg3;
                `DDM_OFS_CONV: rd_data_o <= {18'h00000, converge_judge_time};
                `DDM_OFS_INER_UP: rd_data_o <= 32'(est_lim[0].upper);
                `DDM_OFS_INER_LO: rd_data_o <= 32'(est_lim[0].lower);
                `DDM_OFS_UNBAL_UP: rd_data_o <= 32'(est_lim[1].upper);
                `DDM_OFS_UNBAL_LO: rd_data_o <= 32'(est_lim[1].lower);
                `DDM_OFS_DYN_UP: rd_data_o <= 32'(est_lim[2].upper);
                `DDM_OFS_DYN_LO: rd_data_o <= 32'(est_lim[2].lower);
                `DDM_OFS_VISC_UP: rd_data_o <= 32'(est_lim[3].upper);
                `DDM_OFS_VISC_LO: rd_data_o <= 32'(est_lim[3].lower);
                `DDM_OFS_SPEED_SET: rd_data_o <= 32'(diag_speed_setpoint);
                `DDM_OFS_AVG_TIME: rd_data_o <= {18'h00000, torque_avg_time};
                `DDM_OFS_TRQ_UP: rd_data_o <= 32'(torque_avg_lim.upper);
                `DDM_OFS_TRQ_LO: rd_data_o <= 32'(torque_avg_lim.lower);
                `DDM_OFS_MATCH_W: rd_data_o <= 32'(speed_match_width);
                `DDM_OFS_EST_SPEED: rd_data_o <= {28'h0000000, autotune_est_speed};
                `DDM_OFS_STATUS: rd_data_o <= {28'h0000000, torque_eff, load_eff,
                                               wear_warning_o, diag_flag};
                `DDM_OFS_TRQ_AVG: rd_data_o <= 32'(torque_avg);
                default: rd_data_o <= 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    property p_off; !monitor_en |=> !diag_flag; endproperty
    a_off: assert property (p_off) else $error("flag while disabled");
    property p_on; monitor_en && in_on |=> diag_flag; endproperty
    a_on: assert property (p_on) else $error("flag missing in window");
    property p_hyst; diag_flag && monitor_en && in_hold |=> diag_flag; endproperty
    a_hyst: assert property (p_hyst) else $error("flag dropped in band");
    property p_start; $rose(diag_flag) |-> !torque_eff ##1 !torque_eff; endproperty
    a_start: assert property (p_start) else $error("torque judged early");
    property p_drop; !diag_flag |=> !torque_eff; endproperty
    a_drop: assert property (p_drop) else $error("torque judged outside window");
    property p_zero; $rose(torque_eff) |-> $past(torque_avg_time) != 14'h0000; endproperty
    a_zero: assert property (p_zero) else $error("average with zero time");
    property p_conv; $rose(load_eff) |-> $past(est_stat_i.converged); endproperty
    a_conv: assert property (p_conv) else $error("load judged unconverged");
    property p_latch; load_eff && run_ok |=> load_eff; endproperty
    a_latch: assert property (p_latch) else $error("load judgment lost");
    property p_stop; autotune_est_speed == 4'h0 |=> !load_eff; endproperty
    a_stop: assert property (p_stop) else $error("load judged while stopped");
    property p_warn; (|est_exceed) || torque_exceed |=> wear_warning_o; endproperty
    a_warn: assert property (p_warn) else $error("warning missing");
endmodule
`default_nettype wire

/* rtl/limit_judge.sv */
// Upper and lower limit comparison of one monitored quantity
`default_nettype none
module limit_judge #(
    parameter int LIM_MIN = 0,
    parameter int LIM_MAX = 0,
    parameter int SHIFT = 0
) (
    // Value and limits
    input wire ddm_pkg::val_t value_i,
    input wire ddm_pkg::lim_pair_t lim_i,
    input wire logic judge_i,
    // Result
    output logic exceed_o
);
    // Coarsens to the judgment step by flooring
    function automatic int quant(input ddm_pkg::val_t v);
        quant = int'(v) >>> SHIFT;
    endfunction

    logic both_ok;
    logic up_on;
    logic lo_on;

    assign both_ok = int'(lim_i.upper) > int'(lim_i.lower);
    assign up_on = both_ok && (int'(lim_i.upper) != LIM_MAX);
    assign lo_on = both_ok && (int'(lim_i.lower) != LIM_MIN);
    // Both sides quantised alike, so a finer limit cannot split a step
    assign exceed_o = judge_i && ((up_on && quant(value_i) > quant(lim_i.upper)) ||
                                  (lo_on && quant(value_i) < quant(lim_i.lower)));
endmodule
`default_nettype wire

/* rtl/torque_averager.sv */
// Block average of the torque command inside the velocity window
`include "ddm_consts.svh"
`default_nettype none
module torque_averager (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // Window and samples
    input wire logic window_i,
    input wire logic tick_i,
    input wire logic [13:0] avg_time_i,
    input wire ddm_pkg::val_t torque_i,
    // Result
    output ddm_pkg::val_t avg_o,
    output logic valid_o
);
    logic signed [31:0] sum;
    logic signed [31:0] next_sum;
    logic [13:0] elapsed;
    logic last;

    assign next_sum = sum + 32'(torque_i);
    assign last = tick_i && ((elapsed + 14'h0001) == avg_time_i);

    // ----------------------------------------
    // Accumulation
    // ----------------------------------------
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sum <= 32'sh00000000;
            elapsed <= 14'h0000;
        end else if (!window_i || avg_time_i == 14'h0000) begin
            sum <= 32'sh00000000;
            elapsed <= 14'h0000;
        end else if (last) begin
            sum <= 32'sh00000000;
            elapsed <= 14'h0000;
        end else if (tick_i) begin
            sum <= next_sum;
            elapsed <= elapsed + 14'h0001;
        end
    end

    // ----------------------------------------
    // Average and judgment window
    // ----------------------------------------
    // The divider is wide but only used once per averaging period
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            avg_o <= `DDM_RST_VAL;
            valid_o <= 1'b0;
        end else if (!window_i || avg_time_i == 14'h0000) begin
            valid_o <= 1'b0;
        end else if (last) begin
            avg_o <= ddm_pkg::val_t'(next_sum / $signed({18'h00000, avg_time_i}));
            valid_o <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* shared/ddm_consts.svh */
// Constants of the deterioration diagnosis monitor
`ifndef DDM_CONSTS_SVH
`define DDM_CONSTS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define DDM_CLK_PERIOD_NS 5
`define DDM_MS_NS 1000000
`define DDM_CONV_UNIT_MS 7'h64
`define DDM_HYST_RPM 32'sh0000000A
`define DDM_AUTO_CONV_BASE 14'h012C

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DDM_OFS_CFG 8'h00
`define DDM_OFS_CONV 8'h04
`define DDM_OFS_INER_UP 8'h08
`define DDM_OFS_INER_LO 8'h0C
`define DDM_OFS_UNBAL_UP 8'h10
`define DDM_OFS_UNBAL_LO 8'h14
`define DDM_OFS_DYN_UP 8'h18
`define DDM_OFS_DYN_LO 8'h1C
`define DDM_OFS_VISC_UP 8'h20
`define DDM_OFS_VISC_LO 8'h24
`define DDM_OFS_SPEED_SET 8'h28
`define DDM_OFS_AVG_TIME 8'h2C
`define DDM_OFS_TRQ_UP 8'h30
`define DDM_OFS_TRQ_LO 8'h34
`define DDM_OFS_MATCH_W 8'h38
`define DDM_OFS_EST_SPEED 8'h3C
`define DDM_OFS_STATUS 8'h40
`define DDM_OFS_TRQ_AVG 8'h44

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define DDM_EN_BIT 1
`define DDM_RST_CFG 32'h00000000
`define DDM_RST_VAL 17'h00000
`define DDM_RST_TIME 14'h0000
`define DDM_RST_SPEED 4'h0

// ----------------------------------------
// Setting ranges
// ----------------------------------------
`define DDM_TIME_MAX 32'sh00002710
`define DDM_POS_MIN 32'sh00000000
`define DDM_POS_MAX 32'sh00002710
`define DDM_SGN_MIN 32'shFFFFFC18
`define DDM_SGN_MAX 32'sh000003E8
`define DDM_SPD_MIN 32'shFFFFB1E0
`define DDM_SPD_MAX 32'sh00004E20
`define DDM_EST_MAX 32'sh0000000F

`endif

/* shared/ddm_pkg.sv */
// Types of the deterioration diagnosis monitor
`default_nettype none
package ddm_pkg;
    typedef logic signed [16:0] val_t;
    typedef struct packed {
        val_t upper;
        val_t lower;
    } lim_pair_t;
    typedef struct packed {
        val_t inertia;
        val_t unbal;
        val_t dynfric;
        val_t viscfric;
    } est_t;
    typedef struct packed {
        logic est_on;
        logic cond_ok;
        logic converged;
    } est_stat_t;
    typedef enum logic [1:0] {
        LJ_IDLE = 2'b00,
        LJ_ACCUM = 2'b01,
        LJ_EFFECTIVE = 2'b10
    } load_state_t;
endpackage
`default_nettype wire

/* test/deterioration_diagnosis_monitor_bench.sv */
// Self-checking bench of the deterioration diagnosis monitor
`include "ddm_consts.svh"
`default_nettype none
module deterioration_diagnosis_monitor_bench;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Stimulus and wiring
    // ----------------------------------------
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wr_data_i = 32'h00000000;
    logic wr_stb_i = 1'b0;
    logic rd_stb_i = 1'b0;
    logic [31:0] rd_data_o;
    ddm_pkg::val_t motor_speed_i = 17'h00000;
    ddm_pkg::val_t torque_cmd_i = 17'h00000;
    ddm_pkg::est_t est_i = '0;
    ddm_pkg::est_stat_t est_stat_i = '0;
    logic diag_speed_flag_o;
    logic wear_warning_o;
    int num_errors = 0;
    int check_count = 0;
    // Short tick keeps the 100 ms convergence unit at 1000 cycles
    deterioration_diagnosis_monitor #(.MS_CYCLES(10)) dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i),
        .rd_data_o(rd_data_o), .motor_speed_i(motor_speed_i), .torque_cmd_i(torque_cmd_i),
        .est_i(est_i), .est_stat_i(est_stat_i), .diag_speed_flag_o(diag_speed_flag_o),
        .wear_warning_o(wear_warning_o));
    always #2.5 clock_i = ~clock_i;
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic report_and_stop();
        if (num_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_stb_i <= 1'b1;
        @(posedge clock_i);
        wr_stb_i <= 1'b0;
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock_i);
        addr_i <= a;
        rd_stb_i <= 1'b1;
        @(posedge clock_i);
        rd_stb_i <= 1'b0;
        #1;
        chk(name, exp, rd_data_o);
    endtask
    // Bounded wait for the warning level; a spent bound is a mismatch
    task automatic wait_warn(input logic exp, input int lim);
        int n = 0;
        #1;
        while (wear_warning_o !== exp && n < lim) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        chk("wear_warning", {31'h0, exp}, {31'h0, wear_warning_o});
        if (wear_warning_o !== exp) report_and_stop();
    endtask
    task automatic speed_chk(input int v, input logic exp);
        @(posedge clock_i);
        motor_speed_i <= v[16:0];
        repeat (3) @(posedge clock_i);
        #1;
        chk("diag_speed_flag", {31'h0, exp}, {31'h0, diag_speed_flag_o});
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic regs_after_reset();
        rd_chk("feature_ext_cfg3", `DDM_OFS_CFG, 32'h00000000);
        rd_chk("unmapped", 8'hFC, 32'h00000000);
        wr(`DDM_OFS_STATUS, 32'h0000000F);
        rd_chk("status", `DDM_OFS_STATUS, 32'h00000000);
        chk("wear_warning", 32'h0, {31'h0, wear_warning_o});
        wr(`DDM_OFS_UNBAL_UP, 32'd2000);
        rd_chk("unbal_upper_lim", `DDM_OFS_UNBAL_UP, 32'h000003E8);
        wr(`DDM_OFS_TRQ_LO, 32'hFFFFEC78);
        rd_chk("torque_avg_lower_lim", `DDM_OFS_TRQ_LO, 32'hFFFFFC18);
        wr(`DDM_OFS_INER_UP, 32'd20000);
        rd_chk("inertia_upper_lim", `DDM_OFS_INER_UP, 32'h00002710);
        wr(`DDM_OFS_CONV, 32'd20000);
        rd_chk("converge_judge_time", `DDM_OFS_CONV, 32'h00002710);
        wr(`DDM_OFS_AVG_TIME, 32'hFFFFFFFF);
        rd_chk("torque_avg_time", `DDM_OFS_AVG_TIME, 32'h00000000);
    endtask
    task automatic speed_window();
        wr(`DDM_OFS_SPEED_SET, 32'd1000);
        wr(`DDM_OFS_MATCH_W, 32'd50);
        speed_chk(1050, 1'b0);
        wr(`DDM_OFS_CFG, 32'h00000002);
        speed_chk(1050, 1'b1);
        speed_chk(1060, 1'b1);
        speed_chk(1061, 1'b0);
        speed_chk(1055, 1'b0);
        speed_chk(950, 1'b1);
        speed_chk(940, 1'b1);
        wr(`DDM_OFS_CFG, 32'h00000000);
        speed_chk(1000, 1'b0);
        wr(`DDM_OFS_CFG, 32'h00000002);
    endtask
    task automatic torque_average();
        // Torque set first, so the open window never sums stale zeros
        torque_cmd_i <= 17'h00064;
        wr(`DDM_OFS_AVG_TIME, 32'd3);
        wr(`DDM_OFS_TRQ_UP, 32'd50);
        wr(`DDM_OFS_TRQ_LO, 32'hFFFFFC18);
        speed_chk(1000, 1'b1);
        wait_warn(1'b1, 100);
        rd_chk("torque_avg", `DDM_OFS_TRQ_AVG, 32'h00000064);
        rd_chk("status", `DDM_OFS_STATUS, 32'h0000000B);
        speed_chk(5000, 1'b0);
        wait_warn(1'b0, 5);
        @(posedge clock_i);
        torque_cmd_i <= 17'h1FF38;
        wr(`DDM_OFS_TRQ_UP, 32'd1000);
        wr(`DDM_OFS_TRQ_LO, 32'hFFFFFF9C);
        speed_chk(1000, 1'b1);
        wait_warn(1'b1, 100);
        rd_chk("torque_avg", `DDM_OFS_TRQ_AVG, 32'hFFFFFF38);
        wr(`DDM_OFS_AVG_TIME, 32'd0);
        wait_warn(1'b0, 5);
        repeat (60) @(posedge clock_i);
        wait_warn(1'b0, 1);
        speed_chk(5000, 1'b0);
    endtask
    task automatic load_judgment();
        wr(`DDM_OFS_EST_SPEED, 32'd1);
        wr(`DDM_OFS_CONV, 32'd1);
        wr(`DDM_OFS_INER_UP, 32'd200);
        wr(`DDM_OFS_INER_LO, 32'd100);
        est_i <= '{inertia: 17'd300, unbal: 17'd0, dynfric: 17'd0, viscfric: 17'd0};
        est_stat_i <= '{est_on: 1'b1, cond_ok: 1'b1, converged: 1'b1};
        repeat (500) @(posedge clock_i);
        rd_chk("status", `DDM_OFS_STATUS, 32'h00000000);
        wait_warn(1'b1, 1500);
        rd_chk("status", `DDM_OFS_STATUS, 32'h00000006);
        wr(`DDM_OFS_INER_UP, 32'd10000);
        wait_warn(1'b0, 5);
        wr(`DDM_OFS_INER_UP, 32'd250);
        wr(`DDM_OFS_INER_LO, 32'd250);
        wait_warn(1'b0, 1);
        wr(`DDM_OFS_INER_UP, 32'd10000);
        wr(`DDM_OFS_INER_LO, 32'd400);
        wait_warn(1'b1, 5);
        wr(`DDM_OFS_INER_LO, 32'd0);
        wr(`DDM_OFS_DYN_UP, 32'd100);
        wr(`DDM_OFS_DYN_LO, 32'hFFFFFC18);
        est_i <= '{inertia: 17'd300, unbal: 17'd0, dynfric: 17'd101, viscfric: 17'd0};
        wait_warn(1'b0, 5);
        @(posedge clock_i);
        est_i <= '{inertia: 17'd300, unbal: 17'd0, dynfric: 17'd102, viscfric: 17'd0};
        wait_warn(1'b1, 5);
        wr(`DDM_OFS_VISC_UP, 32'd100);
        est_i <= '{inertia: 17'd300, unbal: 17'd0, dynfric: 17'd0, viscfric: 17'd101};
        wait_warn(1'b0, 5);
        @(posedge clock_i);
        est_i <= '{inertia: 17'd300, unbal: 17'd0, dynfric: 17'd0, viscfric: 17'd102};
        wait_warn(1'b1, 5);
        @(posedge clock_i);
        est_stat_i <= '{est_on: 1'b1, cond_ok: 1'b0, converged: 1'b0};
        repeat (20) @(posedge clock_i);
        wait_warn(1'b1, 1);
        wr(`DDM_OFS_EST_SPEED, 32'd0);
        wait_warn(1'b0, 5);
        rd_chk("status", `DDM_OFS_STATUS, 32'h00000000);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clock_i);
        rst_b_i <= 1'b1;
        regs_after_reset();
        speed_window();
        torque_average();
        load_judgment();
        report_and_stop();
    end
endmodule
`default_nettype wire
